// ---- design/ixe_regs.svh ----
// ixe_regs.svh: opcode patterns, field positions, reset values, timing
// assumes: included by bare name from the package and design modules
`ifndef IXE_REGS_SVH
`define IXE_REGS_SVH

// upper six bits of the 14-bit instruction word
`define IXE_OPC_INCREMENT   6'h0A
`define IXE_OPC_OR_IMM      6'h38
`define IXE_OPC_OR_REG      6'h04
`define IXE_OPC_MOVE        6'h08

// field positions inside the instruction word
`define IXE_OPC_MSB         13
`define IXE_OPC_LSB         8
`define IXE_DEST_BIT        7
`define IXE_ADDR_MSB        6
`define IXE_ADDR_LSB        0
`define IXE_IMM_MSB         7
`define IXE_IMM_LSB         0

// reset values
`define IXE_ACCUM_RST       8'h00
`define IXE_ZERO_RST        1'b0

// clocks per instruction cycle at 20 MHz (200 ns cycle)
`define IXE_CLKS_PER_INSTR  4

`endif

// ---- design/ixe_pkg.sv ----
// ixe_pkg.sv: types shared by the execute unit, its checker and the testbench
// assumes: ixe_regs.svh on the include path
`include "ixe_regs.svh"

package ixe_pkg;

  // decoded operation
  typedef enum logic [2:0] {
    OP_NONE,
    OP_INCREMENT,
    OP_OR_IMM,
    OP_OR_REG,
    OP_MOVE
  } ixe_op_t;

  // instruction word split into its fields
  typedef struct packed {
    logic [5:0] opcode;
    logic       dest;
    logic [6:0] addr;
  } ixe_instr_t;

  // one write to the register file
  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [7:0] data;
  } ixe_wr_t;

endpackage : ixe_pkg

// ---- design/ixe_file_mem.sv ----
// ixe_file_mem.sv: file register memory, one write and one read port
// assumes: single clock, read data registered one edge after address
`timescale 1ns/1ps

module ixe_file_mem #(
  parameter int DEPTH = 128,
  parameter int WIDTH = 8,
  parameter int AW    = 7
) (
  // clock
  input  wire logic             clk,
  // write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // read port
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // contents are undefined until written; no reset on the array
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read, old data on a same-address write
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end

endmodule : ixe_file_mem

// ---- design/ixe_exec.sv ----
// ixe_exec.sv: execute unit for increment, or-immediate, or-register and
// move-register instructions, with its own file register memory.
// assumes: instruction words come from fetch, synchronous to clk; the rest
// of the core preloads file registers through the load port.
//
// Notes on behaviour
// - add one to register; d=0 to accumulator, d=1 back; zero flag.
// - or-immediate ORs low eight bits into accumulator; zero flag.
// - OR accumulator with register; d selects destination; zero flag.
// - move copies register to accumulator (d=0) or rewrites it (d=1).
// - move updates zero flag from moved value, so d=1 tests a register.
`timescale 1ns/1ps
// opcode patterns, field positions and timing counts
`include "ixe_regs.svh"

module ixe_exec #(
  parameter int CLKS_PER_INSTR = `IXE_CLKS_PER_INSTR,
  parameter int DEPTH          = 128
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  // instruction from fetch
  input  wire logic                instr_valid,
  input  wire logic [13:0]         instr_word,
  // preload port from the rest of the core
  input  wire logic                load_en,
  input  wire logic [6:0]          load_addr,
  input  wire logic [7:0]          load_data,
  // architectural state
  output logic      [7:0]          accum,
  output logic                     zero_flag,
  // register file write, mirrored for the rest of the core
  output ixe_pkg::ixe_wr_t         file_wr,
  // end of instruction cycle
  output logic                     retire,
  output logic                     unknown_op,
  output logic                     instr_ready
);

  typedef enum logic [1:0] {
    PH_FETCH,
    PH_READ,
    PH_EXEC,
    PH_WRITE
  } ixe_phase_t;

  ixe_phase_t           phase;
  ixe_pkg::ixe_instr_t  ir;
  ixe_pkg::ixe_op_t     op;
  logic [7:0]           result;
  logic [7:0]           rd_data;
  logic                 to_file;
  logic [7:0]           wait_cnt;
  logic                 mem_wr_en;
  logic [6:0]           mem_wr_addr;
  logic [7:0]           mem_wr_data;
  logic                 instr_seen;

  // opcode in the upper six bits decides the operation
  function automatic ixe_pkg::ixe_op_t decode(input logic [5:0] opc);
    case (opc)
      `IXE_OPC_INCREMENT: decode = ixe_pkg::OP_INCREMENT;
      `IXE_OPC_OR_IMM:    decode = ixe_pkg::OP_OR_IMM;
      `IXE_OPC_OR_REG:    decode = ixe_pkg::OP_OR_REG;
      `IXE_OPC_MOVE:      decode = ixe_pkg::OP_MOVE;
      default:            decode = ixe_pkg::OP_NONE;
    endcase
  endfunction : decode

  // phase sequencer; exec phase stretched so one cycle = CLKS_PER_INSTR
  // a larger count only lengthens exec, so the read data stay valid
  always_ff @(posedge clk) begin
    if (rst) begin
      phase    <= PH_FETCH;
      wait_cnt <= 8'h00;
    end else begin
      case (phase)
        PH_FETCH: phase <= PH_READ;
        PH_READ:  phase <= PH_EXEC;
        PH_EXEC: begin
          if (wait_cnt >= 8'(CLKS_PER_INSTR - 4)) begin
            wait_cnt <= 8'h00;
            phase    <= PH_WRITE;
          end else begin
            wait_cnt <= wait_cnt + 8'h01;
          end
        end
        PH_WRITE: phase <= PH_FETCH;
        default:  phase <= PH_FETCH;
      endcase
    end
  end

  // ready only in fetch phase so the word is taken exactly once
  always_ff @(posedge clk) begin
    if (rst) begin
      instr_ready <= 1'b0;
    end else begin
      instr_ready <= (phase == PH_WRITE);
    end
  end

  // latch the instruction and its decoded operation; fields fixed by
  // position: addr in bits 6..0, destination in bit 7
  always_ff @(posedge clk) begin
    if (rst) begin
      ir <= '0;
      op <= ixe_pkg::OP_NONE;
    end else if (phase == PH_FETCH) begin
      ir <= ixe_pkg::ixe_instr_t'(instr_word);
      op <= instr_valid ? decode(instr_word[`IXE_OPC_MSB:`IXE_OPC_LSB])
                        : ixe_pkg::OP_NONE;
    end
  end

  // compute the result once read data is available
  // read data of the address latched at fetch arrive one edge later, by exec
  always_ff @(posedge clk) begin
    if (rst) begin
      result  <= 8'h00;
      to_file <= 1'b0;
    end else if (phase == PH_EXEC) begin
      to_file <= 1'b0;
      case (op)
        ixe_pkg::OP_INCREMENT: begin
          result  <= rd_data + 8'h01;
          to_file <= ir.dest;
        end
        ixe_pkg::OP_OR_IMM: begin
          result <= accum | {ir.dest, ir.addr};
        end
        ixe_pkg::OP_OR_REG: begin
          result  <= accum | rd_data;
          to_file <= ir.dest;
        end
        ixe_pkg::OP_MOVE: begin
          result  <= rd_data;
          to_file <= ir.dest;
        end
        default: result <= 8'h00;
      endcase
    end
  end

  // commit accumulator and zero flag at the end of the cycle
  // d=1 leaves the accumulator alone; the memory takes the result
  always_ff @(posedge clk) begin
    if (rst) begin
      accum     <= `IXE_ACCUM_RST;
      zero_flag <= `IXE_ZERO_RST;
    end else if (phase == PH_WRITE && op != ixe_pkg::OP_NONE) begin
      if (!to_file) begin
        accum <= result;
      end
      // every one of the four sets or clears zero, move included
      zero_flag <= (result == 8'h00);
    end
  end

  // status pulses, one clock long, at the commit edge
  always_ff @(posedge clk) begin
    if (rst) begin
      retire     <= 1'b0;
      unknown_op <= 1'b0;
    end else begin
      retire     <= (phase == PH_WRITE) && (op != ixe_pkg::OP_NONE);
      unknown_op <= (phase == PH_WRITE) && (op == ixe_pkg::OP_NONE)
                    && instr_seen;
    end
  end

  // remembers whether the fetch phase held a valid word
  always_ff @(posedge clk) begin
    if (rst) begin
      instr_seen <= 1'b0;
    end else if (phase == PH_FETCH) begin
      instr_seen <= instr_valid;
    end
  end

  // write-back wins over preload; a load in that clock is dropped
  always_comb begin
    if (phase == PH_WRITE && op != ixe_pkg::OP_NONE && to_file) begin
      mem_wr_en   = 1'b1;
      mem_wr_addr = ir.addr;
      mem_wr_data = result; // move with d=1 rewrites same value
    end else begin
      mem_wr_en   = load_en;
      mem_wr_addr = load_addr;
      mem_wr_data = load_data;
    end
  end

  // registered mirror of the write-back
  // addr and data follow every memory write; only en marks a write-back
  always_ff @(posedge clk) begin
    if (rst) begin
      file_wr <= '0;
    end else begin
      file_wr.en   <= mem_wr_en && (phase == PH_WRITE) && to_file
                      && (op != ixe_pkg::OP_NONE);
      file_wr.addr <= mem_wr_addr;
      file_wr.data <= mem_wr_data;
    end
  end

  // file registers; address held from fetch onward
  ixe_file_mem #(
    .DEPTH (DEPTH),
    .WIDTH (8),
    .AW    (7)
  ) u_mem (
    .clk     (clk),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data),
    .rd_addr (ir.addr),
    .rd_data (rd_data)
  );

endmodule : ixe_exec

// ---- design/ixe_exec_fix.sv ----
// ixe_exec_fix.sv: intentionally empty companion, no module
// assumes: nothing

// ---- verif/ixe_exec_chk.sv ----
// ixe_exec_chk.sv: port assertions for the execute unit
// assumes: bound to ixe_exec, single clock, rst synchronous high
`timescale 1ns/1ps
`include "ixe_regs.svh"
module ixe_chk (
  // clock and reset
  input wire logic             clk,
  input wire logic             rst,
  // instruction side
  input wire logic             instr_valid,
  input wire logic [13:0]      instr_word,
  input wire logic             instr_ready,
  // results
  input wire logic [7:0]       accum,
  input wire logic             zero_flag,
  input wire ixe_pkg::ixe_wr_t file_wr,
  input wire logic             retire,
  input wire logic             unknown_op
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // decode of the word at its taking edge
  wire logic [5:0] opc = instr_word[13:8];
  wire logic take = instr_ready && instr_valid;
  wire logic known = opc inside {`IXE_OPC_INCREMENT, `IXE_OPC_OR_IMM,
    `IXE_OPC_OR_REG, `IXE_OPC_MOVE};
  wire logic imm = opc == `IXE_OPC_OR_IMM;
  sequence s_wb;
    take && known && !imm && instr_word[7];
  endsequence
  sequence s_acc;
    take && known && (imm || !instr_word[7]);
  endsequence
  // commit pulses are sampled exactly four edges after the taking edge
  AST_RETIRE: assert property (take && known |-> ##4 retire)
    else $error("known word did not retire in one cycle");
  AST_UNKNOWN: assert property (take && !known |-> ##4 unknown_op)
    else $error("unknown word not flagged");
  AST_WB: assert property (s_wb |-> ##4 file_wr.en)
    else $error("register destination not written");
  AST_NO_WB: assert property (
    s_acc |-> ##4 !file_wr.en ##1 !file_wr.en)
    else $error("accumulator destination wrote a register");
  AST_PULSE: assert property (retire |=> !retire)
    else $error("retire longer than one cycle");
  AST_ZERO_ACC: assert property (retire && !file_wr.en |->
    zero_flag == (accum == 8'h00)) else $error("zero flag wrong for accum");
  AST_ZERO_WB: assert property (file_wr.en |->
    retire && zero_flag == (file_wr.data == 8'h00))
    else $error("zero flag wrong for write-back");
  AST_HOLD: assert property (!retire |-> $stable(accum) && $stable(zero_flag))
    else $error("state changed without retire");
  AST_READY: assert property (
    instr_ready |=> !instr_ready [*3] ##1 instr_ready)
    else $error("instruction cycle not four clocks");
endmodule : ixe_chk

bind ixe_exec ixe_chk ixe_chk_i (.clk, .rst, .instr_valid, .instr_word,
  .instr_ready, .accum, .zero_flag, .file_wr, .retire, .unknown_op);

// ---- verif/test_inc_or_move_instr_exec.sv ----
// test_inc_or_move_instr_exec.sv: directed tests of the execute unit
// assumes: design files and checker compiled first
`timescale 1ns/1ps
`include "ixe_regs.svh"
module test_inc_or_move_instr_exec;
  logic             clk, rst, instr_valid, load_en, zero_flag, z_m;
  logic             retire, unknown_op, instr_ready;
  logic [13:0]      instr_word;
  logic [6:0]       load_addr;
  logic [7:0]       load_data, accum, acc_m;
  logic [7:0]       mem_m [128];
  ixe_pkg::ixe_wr_t file_wr;
  int               bad_count, n_tests, cyc;

  ixe_exec ixe_exec_i (.clk, .rst, .instr_valid, .instr_word, .load_en,
    .load_addr, .load_data, .accum, .zero_flag, .file_wr, .retire,
    .unknown_op, .instr_ready);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict;
    $display("mismatches=%0d compares=%0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // preload kept apart from commits: memory has no reset
  task automatic load(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk);
    load_en = 1'b1;
    load_addr = a;
    load_data = d;
    mem_m[a] = d;
    @(negedge clk);
    load_en = 1'b0;
  endtask : load

  // f is {dest, addr} or the immediate; drives, waits, judges
  task automatic run(input logic [5:0] opc, input logic [7:0] f);
    logic [7:0] r;
    logic       k, wb;
    int         n;
    r = 8'h00;
    k = 1'b1;
    n = 0;
    while (instr_ready !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    instr_valid = 1'b1;
    instr_word = {opc, f};
    @(negedge clk);
    instr_valid = 1'b0;
    n = 0;
    while (retire !== 1'b1 && unknown_op !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    case (opc)
      `IXE_OPC_INCREMENT: r = mem_m[f[6:0]] + 8'h01;
      `IXE_OPC_OR_REG:    r = acc_m | mem_m[f[6:0]];
      `IXE_OPC_MOVE:      r = mem_m[f[6:0]];
      `IXE_OPC_OR_IMM:    r = acc_m | f;
      default:            k = 1'b0;
    endcase
    wb = k && f[7] && opc != `IXE_OPC_OR_IMM;
    if (k && !wb) acc_m = r;
    if (wb) mem_m[f[6:0]] = r;
    if (k) z_m = (r == 8'h00);
    chk(16'(retire), 16'(k));
    chk(16'(unknown_op), 16'(!k));
    chk(16'(accum), 16'(acc_m));
    chk(16'(zero_flag), 16'(z_m));
    chk(16'(file_wr.en), 16'(wb));
    if (wb) chk(file_wr, {1'b1, f[6:0], r});
  endtask : run

  task automatic t_increment;
    load(7'h7f, 8'hff);
    run(`IXE_OPC_INCREMENT, 8'hff);
    run(`IXE_OPC_INCREMENT, 8'h7f);
  endtask : t_increment

  task automatic t_or_imm;
    load(7'h09, 8'h9a);
    run(`IXE_OPC_MOVE, 8'h09);
    run(`IXE_OPC_OR_IMM, 8'h35);
    load(7'h01, 8'h00);
    run(`IXE_OPC_MOVE, 8'h01);
    run(`IXE_OPC_OR_IMM, 8'h00);
  endtask : t_or_imm

  task automatic t_or_reg;
    load(7'h03, 8'h13);
    load(7'h04, 8'h91);
    run(`IXE_OPC_MOVE, 8'h04);
    run(`IXE_OPC_OR_REG, 8'h03);
    run(`IXE_OPC_OR_REG, 8'h84);
  endtask : t_or_reg

  task automatic t_move;
    load(7'h00, 8'h00);
    run(`IXE_OPC_MOVE, 8'h80);
    run(`IXE_OPC_MOVE, 8'h84);
    run(`IXE_OPC_MOVE, 8'h80);
    run(`IXE_OPC_MOVE, 8'h00);
    run(6'h3f, 8'h84);
  endtask : t_move

  // clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // hang guard, far above the fewer than a hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr_word = 14'h0000;
    load_en = 1'b0;
    load_addr = 7'h00;
    load_data = 8'h00;
    acc_m = 8'h00;
    z_m = 1'b0;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    t_increment();
    t_or_imm();
    t_or_reg();
    t_move();
    print_verdict();
  end
endmodule : test_inc_or_move_instr_exec
